// >>> rtl/erln_consts.svh
/*
 Constants of the error report line node: frame layout, error type
 codes and bit counts. Assumes one common system clock for all nodes.
*/
// Notes on behaviour
// - Frame: 2 start, 1 sequence, 4 type, 9 node id, 1 parity bits.
// - Idle line is zero; a frame opens with one then zero.
// - Sequence bit is 0 in the original report, 1 in rebroadcasts.
// - Error type is a plain 4-bit binary code, sixteen types.
// - Node id is fixed location: 3-bit bus, 6-bit module; 63 invalid.
// - Final bit gives even parity over the whole frame.
// - Dual bus line receiver drops a bad copy and uses the other.
// - Both copies bad turns into a report from this node: no-error type, or bus line failure type once override is set.
// - Memory node has two bus line connections, one enabled by select.
// - Select to line buffers is held when master and checker disagree.
// - First phase: detector sends on its bus line, sequence cleared.
// - Valid two-bit start on the bus line stops normal operation.
// - Transfer error drives first start bit within one clock.
// - Transfer receiver waits two cycles before using its data.
// - Second phase: bus node resends bus report on module line, seq set.
// - Third phase: bus node resends module report on bus line, seq set.
// - Bus report with sequence set is logged; reporting cycle complete.
// - Earliest started report wins; same-cycle starts go by priority.
// - Keep driving only while readback equals the bit sent.
// - A started phase on a line blocks our own report on it.
// - Line error sets pending flag; pass no-error report, report later.
`ifndef ERLN_CONSTS_SVH
`define ERLN_CONSTS_SVH
`define ERLN_CLK_NS 20
`define ERLN_START_PAT 2'h2
`define ERLN_BODY_LAST 4'he
`define ERLN_TX_LAST 5'h10
`define ERLN_MOD_BAD 6'h3f
`define ERLN_TYPE_BUSLINE 4'hf
`define ERLN_TYPE_MODLINE 4'he
`define ERLN_TYPE_NOERR 4'ha
`endif

// >>> rtl/erln_pkg.sv
/*
 Types shared by the error report line node and its line receiver.
 Assumes the constants header sits beside it.
*/
`include "erln_consts.svh"
package erln_pkg;
	typedef struct packed {
		logic seq;
		logic [3:0] etype;
		logic [8:0] node_id;
	} erln_msg_t;

	typedef struct packed {
		logic active;
		logic drain;
		logic start_ok;
		logic bad_start;
		logic done;
		logic valid;
		erln_msg_t msg;
	} erln_rx_t;

	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BODY, RX_DRAIN}
		erln_rxst_t;

	function automatic logic [16:0] erln_frame(input erln_msg_t m);
		return {`ERLN_START_PAT, m, ~(^m)};
	endfunction
endpackage

// >>> rtl/erln_rx.sv
/*
 Serial receiver for one report line copy.
 Assumes the line input is already synchronised to mclk.
*/
`timescale 1ns/1ps
`include "erln_consts.svh"
module erln_rx (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic line,
	output erln_pkg::erln_rx_t stat
);
	import erln_pkg::*;
	erln_rxst_t st;
	erln_rxst_t next_st;
	logic [3:0] cnt;
	logic [13:0] sh;
	logic [14:0] body;

	assign body = {sh, line};

	always_comb begin
		next_st = st;
		unique case (st)
			RX_IDLE: if (line) next_st = RX_START;
			RX_START: next_st = line ? RX_DRAIN : RX_BODY;
			RX_BODY: if (cnt == `ERLN_BODY_LAST) next_st = RX_IDLE;
			RX_DRAIN: if (!line) next_st = RX_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) st <= RX_IDLE;
		else st <= next_st;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 4'h0;
			sh <= 14'h0;
		end else if (st == RX_BODY) begin
			cnt <= cnt + 4'h1;
			sh <= body[13:0];
		end else begin
			cnt <= 4'h0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			stat <= '0;
		end else begin
			stat.active <= next_st == RX_START || next_st == RX_BODY;
			stat.drain <= next_st == RX_DRAIN;
			stat.start_ok <= st == RX_START && !line;
			stat.bad_start <= st == RX_START && line;
			stat.done <= st == RX_BODY && cnt == `ERLN_BODY_LAST;
			// Start pattern contributes a single one to the parity
			stat.valid <= ~(^{1'b1, body});
			if (st == RX_BODY && cnt == `ERLN_BODY_LAST)
				stat.msg <= body[14:1];
		end
	end

	AST_RX_START:
	assert property (@(posedge mclk) disable iff (!rst_n)
		stat.start_ok |-> !$past(line) && $past(line, 2))
	else $error("start accepted without one-zero pattern");

	AST_RX_COUNT:
	assert property (@(posedge mclk) disable iff (!rst_n)
		stat.done |-> $past(st) == RX_BODY && $past(cnt) == 4'he)
	else $error("frame ended at wrong bit count");
endmodule

// >>> rtl/erln_node.sv
/*
 Error report line node: sends, receives, relays and logs error reports
 on a duplicated bus report line and a module report line.
 Assumes wired-OR lines sampled on the common mclk; line inputs are
 synchronised here, request inputs come from mclk logic.
*/
`timescale 1ns/1ps
`include "erln_consts.svh"
module erln_node #(
	parameter bit IS_MEMCTL = 1'b0
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [2:0] bus_num,
	input wire logic [5:0] module_num,
	input wire logic [1:0] bus_error_report_line_in0,
	input wire logic [1:0] bus_error_report_line_in1,
	input wire logic module_error_report_line_in,
	input wire logic memory_bus_select_master,
	input wire logic memory_bus_select_checker,
	input wire logic err_detect,
	input wire logic [3:0] err_type,
	input wire logic xfer_end,
	output logic bus_report_line_output,
	output logic [1:0] bus_report_line_oe,
	output logic module_error_report_line_out,
	output logic module_error_report_line_oe,
	output logic halt_op,
	output logic xfer_commit,
	output logic log_valid,
	output erln_pkg::erln_msg_t log_msg,
	output logic sel_mismatch,
	output logic id_invalid
);
	import erln_pkg::*;
	logic [1:0] rst_sync;
	logic rst_n;
	logic [4:0] pin_s1;
	logic [4:0] pin_s2;
	logic sel_hold;
	logic [8:0] node_id;
	logic id_taken;
	logic [1:0] cpy;
	erln_rx_t rxs [2];
	erln_rx_t rxm;
	logic [1:0] fin_bad;
	logic decided;
	logic [1:0] bad_now;
	logic got;
	logic fail;
	logic bus_evt;
	logic complete;
	erln_msg_t ev_msg;
	logic m_got;
	logic m_bad;
	logic pend_bus;
	logic pend_mod;
	logic override;
	logic ph3_seen;
	logic [1:0] new_req;
	erln_msg_t new_msg [2];
	logic [1:0] req_v;
	erln_msg_t req_m [2];
	logic [1:0] cand_v;
	erln_msg_t cand_m [2];
	logic [1:0] line_act;
	logic [1:0] start;
	logic [1:0] tx_act;
	logic [16:0] tx_sh [2];
	logic [4:0] tx_cnt [2];
	logic [1:0] drive;
	logic [1:0] next_drive;
	logic [1:0] next_act;
	logic [1:0] p1;
	logic [1:0] p2;
	logic [1:0] v1;
	logic [1:0] v2;
	logic [1:0] rb;
	logic [1:0] lost;
	logic bus_start;
	logic xp1;
	logic xp2;
	logic stop;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) rst_sync <= 2'h0;
		else rst_sync <= {rst_sync[0], 1'b1};
	end
	assign rst_n = rst_sync[1];

	// Line pins carry every node's drive, our own included, for readback
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1 <= 5'h0;
			pin_s2 <= 5'h0;
		end else begin
			pin_s1 <= {module_error_report_line_in,
				bus_error_report_line_in1, bus_error_report_line_in0};
			pin_s2 <= pin_s1;
		end
	end

	// Location straps are caught once after reset release
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			node_id <= 9'h0;
			id_taken <= 1'b0;
			id_invalid <= 1'b0;
		end else if (!id_taken) begin
			node_id <= {bus_num, module_num};
			id_taken <= 1'b1;
			id_invalid <= module_num == `ERLN_MOD_BAD;
		end
	end

	// A select fault must not reach both buses' buffers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sel_hold <= 1'b0;
			sel_mismatch <= 1'b0;
		end else begin
			sel_mismatch <=
				memory_bus_select_master != memory_bus_select_checker;
			if (IS_MEMCTL && memory_bus_select_master ==
				memory_bus_select_checker)
				sel_hold <= memory_bus_select_master;
		end
	end

	assign cpy = sel_hold ? pin_s2[3:2] : pin_s2[1:0];

	for (genvar gi = 0; gi < 2; gi++) begin : g_cp
		erln_rx u_rx (
			.mclk(mclk),
			.rst_n(rst_n),
			.line(cpy[gi]),
			.stat(rxs[gi])
		);
	end

	erln_rx u_rxm (
		.mclk(mclk),
		.rst_n(rst_n),
		.line(pin_s2[4]),
		.stat(rxm)
	);

	// Copy selection and failure conversion on the dual line
	always_comb begin
		got = 1'b0;
		ev_msg = rxs[0].msg;
		for (int i = 0; i < 2; i++)
			bad_now[i] = rxs[i].bad_start || (rxs[i].done && !rxs[i].valid);
		if (!decided && rxs[0].done && rxs[0].valid) begin
			got = 1'b1;
		end else if (!decided && rxs[1].done && rxs[1].valid) begin
			got = 1'b1;
			ev_msg = rxs[1].msg;
		end
		fail = !decided && !got && |bad_now &&
			&(bad_now | fin_bad | {rxs[1].drain, rxs[0].drain});
		if (fail) begin
			ev_msg.seq = ph3_seen;
			ev_msg.etype = override ? `ERLN_TYPE_BUSLINE
				: `ERLN_TYPE_NOERR;
			ev_msg.node_id = node_id;
		end
		bus_evt = got || fail;
		complete = bus_evt && ev_msg.seq;
		m_got = rxm.done && rxm.valid;
		m_bad = rxm.bad_start || (rxm.done && !rxm.valid);
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			fin_bad <= 2'h0;
			decided <= 1'b0;
		end else if (!rxs[0].active && !rxs[1].active && !bus_evt &&
			!(|bad_now)) begin
			fin_bad <= 2'h0;
			decided <= 1'b0;
		end else begin
			fin_bad <= fin_bad | bad_now;
			decided <= decided | bus_evt;
		end
	end

	// Line faults are held back so every log stays identical
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pend_bus <= 1'b0;
			pend_mod <= 1'b0;
			override <= 1'b0;
			ph3_seen <= 1'b0;
		end else begin
			pend_bus <= (pend_bus && !complete) || fail;
			pend_mod <= (pend_mod && !complete) || m_bad;
			if (complete)
				override <= pend_bus || pend_mod || m_bad || fail;
			ph3_seen <= (ph3_seen && !complete) || m_got || m_bad;
		end
	end

	// New reports; a relay has progressed further than a local one
	always_comb begin
		new_req = 2'h0;
		new_msg[0] = '{seq: 1'b0, etype: err_type, node_id: node_id};
		new_msg[1] = ev_msg;
		new_msg[1].seq = 1'b1;
		if (!IS_MEMCTL && bus_evt && !ev_msg.seq)
			new_req[1] = 1'b1;
		if (!IS_MEMCTL && (m_got || m_bad)) begin
			new_req[0] = 1'b1;
			new_msg[0] = rxm.msg;
			new_msg[0].seq = 1'b1;
			if (m_bad) begin
				new_msg[0].etype = override ? `ERLN_TYPE_MODLINE
					: `ERLN_TYPE_NOERR;
				new_msg[0].node_id = node_id;
			end
		end else if (err_detect) begin
			new_req[0] = 1'b1;
		end
	end

	assign line_act = {rxm.active, rxs[0].active || rxs[1].active};
	// Readback of a dual line: a one on either copy counts
	assign rb = {pin_s2[4], cpy[0] || cpy[1]};

	always_comb begin
		for (int k = 0; k < 2; k++) begin
			cand_v[k] = req_v[k] || new_req[k];
			cand_m[k] = new_req[k] ? new_msg[k] : req_m[k];
			start[k] = cand_v[k] && !tx_act[k] && !line_act[k];
			lost[k] = v2[k] && (p2[k] != rb[k]);
			next_act[k] = start[k] ||
				(tx_act[k] && !lost[k] && tx_cnt[k] != `ERLN_TX_LAST);
			next_drive[k] = start[k] ? 1'b1
				: (next_act[k] && tx_sh[k][15]);
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			req_v <= 2'h0;
			req_m[0] <= '0;
			req_m[1] <= '0;
		end else begin
			for (int k = 0; k < 2; k++) begin
				// A phase already running on the line kills our own
				req_v[k] <= cand_v[k] && !start[k] &&
					!(line_act[k] && !tx_act[k]);
				if (new_req[k]) req_m[k] <= new_msg[k];
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tx_act <= 2'h0;
			tx_sh[0] <= 17'h0;
			tx_sh[1] <= 17'h0;
			tx_cnt[0] <= 5'h0;
			tx_cnt[1] <= 5'h0;
		end else begin
			for (int k = 0; k < 2; k++) begin
				tx_act[k] <= next_act[k];
				if (start[k]) begin
					tx_sh[k] <= erln_frame(cand_m[k]);
					tx_cnt[k] <= 5'h0;
				end else if (tx_act[k]) begin
					tx_sh[k] <= {tx_sh[k][15:0], 1'b0};
					tx_cnt[k] <= tx_cnt[k] + 5'h1;
				end
			end
		end
	end

	// Sent bits aligned with the two-stage readback delay
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			drive <= 2'h0;
			p1 <= 2'h0;
			p2 <= 2'h0;
			v1 <= 2'h0;
			v2 <= 2'h0;
		end else begin
			drive <= next_drive;
			p1 <= drive;
			p2 <= p1;
			v1 <= tx_act | start;
			v2 <= v1 & tx_act;
		end
	end

	// Wired-OR: only a one is driven, a zero releases the line
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bus_report_line_output <= 1'b0;
			bus_report_line_oe <= 2'h0;
			module_error_report_line_out <= 1'b0;
			module_error_report_line_oe <= 1'b0;
		end else begin
			bus_report_line_output <= next_drive[0];
			bus_report_line_oe <= {sel_hold && next_drive[0],
				!sel_hold && next_drive[0]};
			module_error_report_line_out <= next_drive[1];
			module_error_report_line_oe <= next_drive[1];
		end
	end

	assign bus_start = rxs[0].start_ok || rxs[1].start_ok;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) halt_op <= 1'b0;
		else halt_op <= bus_start || (halt_op && !complete);
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			log_valid <= 1'b0;
			log_msg <= '0;
		end else begin
			log_valid <= complete;
			if (complete) log_msg <= ev_msg;
		end
	end

	// Trade-off: line sync delay may let a late start slip past the wait
	assign stop = halt_op || bus_start || tx_act[0];
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			xp1 <= 1'b0;
			xp2 <= 1'b0;
			xfer_commit <= 1'b0;
		end else begin
			xp1 <= xfer_end && !start[0];
			xp2 <= xp1 && !stop;
			xfer_commit <= xp2 && !stop;
		end
	end

	AST_STOP:
	assert property (@(posedge mclk) disable iff (!rst_n)
		bus_start |=> halt_op)
	else $error("valid start did not stop operation");

	AST_LOCAL_START:
	assert property (@(posedge mclk) disable iff (!rst_n)
		err_detect && !tx_act[0] && !line_act[0] && !rxm.done &&
		!rxm.bad_start |=> bus_report_line_output && |bus_report_line_oe)
	else $error("first start bit not driven one clock after error");

	AST_WAIT:
	assert property (@(posedge mclk) disable iff (!rst_n)
		xfer_commit |-> $past(xfer_end, 3) && !$past(halt_op))
	else $error("transfer used before the two-cycle wait");

	AST_LOG:
	assert property (@(posedge mclk) disable iff (!rst_n)
		complete |=> log_valid && log_msg == $past(ev_msg) && !halt_op)
	else $error("completed report not logged");

	AST_ONE_CONN:
	assert property (@(posedge mclk) disable iff (!rst_n)
		!(&bus_report_line_oe))
	else $error("both bus line connections enabled");

	AST_SEL_HOLD:
	assert property (@(posedge mclk) disable iff (!rst_n)
		memory_bus_select_master != memory_bus_select_checker
		|=> $stable(sel_hold))
	else $error("select moved during disagreement");

	AST_LOSE:
	assert property (@(posedge mclk) disable iff (!rst_n)
		tx_act[0] && lost[0] |=> !bus_report_line_output && !tx_act[0])
	else $error("kept driving after losing arbitration");

	AST_FRAME_START:
	assert property (@(posedge mclk) disable iff (!rst_n)
		start[1] |=> module_error_report_line_oe ##1
		!module_error_report_line_oe)
	else $error("frame does not open with one then zero");

	AST_BOTH_BAD:
	assert property (@(posedge mclk) disable iff (!rst_n)
		fail |-> bus_evt && ev_msg.node_id == node_id)
	else $error("double copy failure not converted");
endmodule

// >>> testbench/erln_far.sv
/*
 Far-side nodes on the report lines: sends whole frames on the two bus
 line copies and on the module line. Assumes the bench clock mclk and
 that the bench ORs these drives with the node's enables.
*/
`timescale 1ns/1ps
module erln_far (
	input wire logic mclk,
	output logic [1:0] bus,
	output logic modl
);
	initial begin
		bus = 2'h0;
		modl = 1'b0;
	end

	// Each copy set in bad gets its parity bit flipped, a copy not set stays clean
	task automatic send(input logic [16:0] f, input logic [1:0] bad,
		input logic on_mod);
		for (int i = 16; i >= 0; i--) begin
			@(negedge mclk);
			if (on_mod) begin
				modl = f[i];
			end else begin
				bus = {2{f[i]}} ^ ((i == 0) ? bad : 2'h0);
			end
		end
		@(negedge mclk);
		// Released lines fall back to the pulled idle level
		bus = 2'h0;
		modl = 1'b0;
	endtask
endmodule

// >>> testbench/tb.sv
/*
 Self-checking bench: a bus interface node and a memory control node
 share one bus line pair and the module line with the far-side model.
 Assumes the package and design files are compiled first.
*/
`timescale 1ns/1ps
module tb;
	import erln_pkg::*;
	logic mclk, resetn, err_detect, err_m, xfer_end, sel_m, sel_c;
	logic [2:0] bus_num, b;
	logic [5:0] module_num, m;
	logic [3:0] err_type, t;
	logic [1:0] far_bus, oe_n, oe_m, line_a, line_b;
	logic far_mod, out_n, mod_out, mod_oe, line_mod, seen;
	logic halt_op, xfer_commit, log_valid, sel_mis, id_inv;
	logic [16:0] f;
	erln_msg_t log_msg;
	int bad_count = 0, check_count = 0, cyc = 0, w;
	logic [12:0] rows [16] = '{
		{4'h0,3'h0,6'h00},{4'h1,3'h7,6'h3e},{4'h2,3'h5,6'h15},
		{4'h3,3'h2,6'h2a},{4'h4,3'h1,6'h01},{4'h5,3'h6,6'h20},
		{4'h6,3'h3,6'h0f},{4'h7,3'h4,6'h30},{4'h8,3'h0,6'h3e},
		{4'h9,3'h7,6'h00},{4'ha,3'h2,6'h11},{4'hb,3'h5,6'h2e},
		{4'hc,3'h1,6'h1c},{4'hd,3'h6,6'h07},{4'he,3'h3,6'h39},
		{4'hf,3'h4,6'h22}};

	// Wired-OR: a line is active when any party enables its driver
	assign line_a = far_bus | {2{oe_n[0]}} | {2{oe_m[0]}};
	assign line_b = {2{oe_m[1]}};
	assign line_mod = far_mod | mod_oe;

	erln_node i_erln_node (.mclk(mclk), .resetn(resetn), .bus_num(bus_num),
		.module_num(module_num), .bus_error_report_line_in0(line_a),
		.bus_error_report_line_in1(2'h0),
		.module_error_report_line_in(line_mod),
		.memory_bus_select_master(sel_m), .memory_bus_select_checker(sel_c),
		.err_detect(err_detect), .err_type(err_type), .xfer_end(xfer_end),
		.bus_report_line_output(out_n), .bus_report_line_oe(oe_n),
		.module_error_report_line_out(mod_out),
		.module_error_report_line_oe(mod_oe), .halt_op(halt_op),
		.xfer_commit(xfer_commit), .log_valid(log_valid),
		.log_msg(log_msg), .sel_mismatch(), .id_invalid(id_inv));

	erln_node #(.IS_MEMCTL(1'b1)) i_erln_node_mem (.mclk(mclk),
		.resetn(resetn), .bus_num(bus_num), .module_num(6'h05),
		.bus_error_report_line_in0(line_a),
		.bus_error_report_line_in1(line_b),
		.module_error_report_line_in(line_mod),
		.memory_bus_select_master(sel_m), .memory_bus_select_checker(sel_c),
		.err_detect(err_m), .err_type(err_type), .xfer_end(1'b0),
		.bus_report_line_output(), .bus_report_line_oe(oe_m),
		.module_error_report_line_out(), .module_error_report_line_oe(),
		.halt_op(), .xfer_commit(), .log_valid(), .log_msg(),
		.sel_mismatch(sel_mis), .id_invalid());

	erln_far i_erln_far (.mclk(mclk), .bus(far_bus), .modl(far_mod));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	task automatic chk_bit(input string n, input logic e, input logic s);
		check_count++;
		if (s !== e) begin
			bad_count++;
			$display("FAIL %s exp %b got %b", n, e, s);
		end
	endtask

	task automatic chk_val(input string n, input logic [16:0] e,
		input logic [16:0] s);
		check_count++;
		if (s !== e) begin
			bad_count++;
			$display("FAIL %s exp %h got %h", n, e, s);
		end
	endtask

	task automatic end_of_test;
		$display("checks %0d errors %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	function automatic logic [16:0] fr(input logic s, input logic [3:0] x,
		input logic [2:0] y, input logic [5:0] z);
		return {2'h2, s, x, y, z, ^{1'b1, s, x, y, z}};
	endfunction

	// Straps are caught only after reset, so each new id needs a reset
	task automatic do_reset(input logic [2:0] rb, input logic [5:0] rm);
		@(negedge mclk);
		resetn = 1'b0;
		bus_num = rb;
		module_num = rm;
		repeat (8) @(negedge mclk);
		chk_bit("halt in reset", 1'b0, halt_op);
		chk_bit("oe in reset", 1'b0, oe_n[0]);
		resetn = 1'b1;
		repeat (5) @(negedge mclk);
	endtask

	task automatic local_err(input logic [3:0] lt);
		err_type = lt;
		err_detect = 1'b1;
		@(negedge mclk);
		err_detect = 1'b0;
	endtask

	task automatic cap(input logic on_mod, output logic [16:0] cf,
		output int cw);
		cf = '0;
		cw = 0;
		while ((on_mod ? mod_out : out_n) !== 1'b1 && cw < 300) begin
			@(negedge mclk);
			cw++;
		end
		for (int i = 16; i >= 0; i--) begin
			cf[i] = on_mod ? mod_out : out_n;
			@(negedge mclk);
		end
	endtask

	task automatic wait_log(input erln_msg_t e);
		int n;
		n = 0;
		while (log_valid !== 1'b1 && n < 100) begin
			@(negedge mclk);
			n++;
		end
		chk_bit("log_valid", 1'b1, log_valid);
		chk_val("log_msg", 17'(e), 17'(log_msg));
		repeat (2) @(negedge mclk);
		chk_bit("halt clear", 1'b0, halt_op);
	endtask

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			end_of_test();
		end
	end

	initial begin
		resetn = 1'b0;
		{err_detect, err_m, xfer_end, sel_m, sel_c} = 5'h00;
		bus_num = 3'h0;
		module_num = 6'h00;
		err_type = 4'h0;
		foreach (rows[r]) begin
			{t, b, m} = rows[r];
			do_reset(b, m);
			chk_bit("id_invalid", 1'b0, id_inv);
			local_err(t);
			cap(1'b0, f, w);
			chk_bit("start lag", 1'b1, w == 0);
			chk_val("phase1", fr(1'b0, t, b, m), f);
			chk_bit("halt", 1'b1, halt_op);
			cap(1'b1, f, w);
			chk_val("phase2", fr(1'b1, t, b, m), f);
			cap(1'b0, f, w);
			chk_val("phase3", fr(1'b1, t, b, m), f);
			wait_log({1'b1, t, b, m});
		end
		// One bad copy each time; our own report must stay off the line
		for (int k = 0; k < 2; k++) begin
			do_reset(3'h2, 6'h11);
			seen = 1'b0;
			fork
				i_erln_far.send(fr(1'b1, 4'h9, 3'h5, 6'h21), 2'(k + 1), 1'b0);
				begin
					repeat (8) @(negedge mclk);
					chk_bit("halt far", 1'b1, halt_op);
					local_err(4'h3);
					repeat (12) begin
						@(negedge mclk);
						seen = seen | oe_n[0];
					end
				end
			join
			chk_bit("blocked", 1'b0, seen);
			wait_log({1'b1, 4'h9, 3'h5, 6'h21});
		end
		do_reset(3'h6, 6'h0c);
		i_erln_far.send(fr(1'b0, 4'h8, 3'h1, 6'h02), 2'h3, 1'b0);
		cap(1'b1, f, w);
		chk_val("both bad", fr(1'b1, 4'ha, 3'h6, 6'h0c), f);
		// The held-back line fault arms the override for the next cycle
		wait_log({1'b1, 4'ha, 3'h6, 6'h0c});
		i_erln_far.send(fr(1'b0, 4'h8, 3'h1, 6'h02), 2'h3, 1'b0);
		cap(1'b1, f, w);
		chk_val("override", fr(1'b1, 4'hf, 3'h6, 6'h0c), f);
		// Same-cycle reports: the first differing one on the line wins
		do_reset(3'h4, 6'h00);
		err_m = 1'b1;
		local_err(4'h6);
		err_m = 1'b0;
		cap(1'b1, f, w);
		chk_val("arb winner", fr(1'b1, 4'h6, 3'h4, 6'h05), f);
		do_reset(3'h1, 6'h02);
		xfer_end = 1'b1;
		@(negedge mclk);
		xfer_end = 1'b0;
		@(negedge mclk);
		chk_bit("commit early", 1'b0, xfer_commit);
		@(negedge mclk);
		chk_bit("commit", 1'b1, xfer_commit);
		xfer_end = 1'b1;
		local_err(4'h8);
		xfer_end = 1'b0;
		repeat (3) @(negedge mclk);
		chk_bit("commit killed", 1'b0, xfer_commit);
		sel_m = 1'b1;
		sel_c = 1'b1;
		do_reset(3'h0, 6'h3f);
		chk_bit("id 63", 1'b1, id_inv);
		sel_m = 1'b0;
		repeat (2) @(negedge mclk);
		chk_bit("sel_mismatch", 1'b1, sel_mis);
		err_type = 4'h5;
		err_m = 1'b1;
		@(negedge mclk);
		err_m = 1'b0;
		chk_bit("held conn", 1'b1, oe_m[1] & ~oe_m[0]);
		repeat (20) @(negedge mclk);
		end_of_test();
	end
endmodule
